/* core/ptr_consts.svh */
// register map, field positions, reset values and timing counts
`ifndef PTR_CONSTS_SVH
`define PTR_CONSTS_SVH

// register byte offsets
`define PTR_CMD_OFS        8'h00
`define PTR_OPT_OFS        8'h04
`define PTR_STATE_OFS      8'h08
`define PTR_REF_OFS        8'h0c
`define PTR_FBK_OFS        8'h10
`define PTR_BW_OFS         8'h14
`define PTR_PRESET_OFS     8'h18
`define PTR_KI_OFS         8'h1c
`define PTR_IHI_OFS        8'h20
`define PTR_ILO_OFS        8'h24
`define PTR_KP_OFS         8'h28
`define PTR_OHI_OFS        8'h2c
`define PTR_OLO_OFS        8'h30
`define PTR_IMON_OFS       8'h34
`define PTR_OUT_OFS        8'h38

// field positions
`define PTR_TRIM_EN_BIT    12
`define PTR_UNCOND_EN_BIT  23
`define PTR_RUNNING_BIT    1
`define PTR_TRIM_STATE_BIT 31

// per-unit scaling: signed q16.16, 1 pu = 100 %
`define PTR_ONE_PU         32'sh0001_0000
`define PTR_MAX_UPPER      32'sh0008_0000
`define PTR_ZERO           32'sh0000_0000

// reset values
`define PTR_RST_IHI        32'sh0001_0000
`define PTR_RST_ILO        32'shffff_0000
`define PTR_RST_OHI        32'sh0001_0000
`define PTR_RST_OLO        32'shffff_0000

// update period and derived counts
`define PTR_CLK_NS         250'd4
`define PTR_UPDATE_NS      10000
`define PTR_CLK_PERIOD_NS  4
`define PTR_UPDATE_CYC     (`PTR_UPDATE_NS / `PTR_CLK_PERIOD_NS)
`define PTR_DT_Q32 \
  ((64'd`PTR_UPDATE_NS * 64'h0000_0001_0000_0000) / 64'd1000000000)

`endif

/* core/ptr_pkg.sv */
// types and fixed-point helpers of the process trim regulator
package ptr_pkg;

  typedef logic signed [31:0] ptr_pu_t;

  // saturate a wide value to 32 bits
  function automatic ptr_pu_t ptr_sat(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7fff_ffff) begin
      return 32'sh7fff_ffff;
    end else if (v < -64'sh0000_0000_8000_0000) begin
      return 32'sh8000_0000;
    end
    return v[31:0];
  endfunction : ptr_sat

  // q16.16 product with saturation
  function automatic ptr_pu_t ptr_mul(input ptr_pu_t a, input ptr_pu_t b);
    logic signed [63:0] p;
    p = a * b;
    return ptr_sat(p >>> 16);
  endfunction : ptr_mul

  // rate in 1/s times update period, q16.16, capped at one
  function automatic ptr_pu_t ptr_per_step(input ptr_pu_t rate,
                                           input logic [31:0] dt_q32);
    logic [63:0] p;
    p = {32'h0000_0000, rate[31] ? 32'h0000_0000 : rate} *
        {32'h0000_0000, dt_q32};
    // product carries 48 fraction bits; keep 16 of them
    if (p[63:32] > 32'h0001_0000) begin
      return 32'sh0001_0000;
    end
    return p[63:32];
  endfunction : ptr_per_step

  // bound a value between lower and upper limits
  function automatic ptr_pu_t ptr_clamp(input ptr_pu_t v,
                                        input ptr_pu_t lo,
                                        input ptr_pu_t hi);
    if (v > hi) begin
      return hi;
    end else if (v < lo) begin
      return lo;
    end
    return v;
  endfunction : ptr_clamp

endpackage : ptr_pkg

/* core/ptr_err_filter.sv */
// first-order low-pass filter of the regulator error
`timescale 1ns/1ns
`include "ptr_consts.svh"

module ptr_err_filter
  import ptr_pkg::*;
(
  input  wire logic    ref_clk,  // system clock
  input  wire logic    reset,    // synchronous, active high
  input  wire logic    strobe,   // regulator update enable
  input  wire ptr_pu_t err_in,   // unfiltered error
  input  wire ptr_pu_t coef,     // bandwidth times period, q16.16
  output ptr_pu_t      filt_out  // filtered error
);

  ptr_pu_t filt_reg;
  ptr_pu_t filt_next;
  ptr_pu_t delta;

  // step toward the input by coef of the distance
  always_comb begin
    delta     = ptr_sat(64'(err_in) - 64'(filt_reg));
    filt_next = ptr_sat(64'(filt_reg) + 64'(ptr_mul(coef, delta))); // RULE2
  end

  // filter state moves only on the update strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      filt_reg <= `PTR_ZERO;
    end else if (strobe) begin
      filt_reg <= filt_next; // RULE1
    end
  end

  assign filt_out = filt_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_filt_hold_between: assert property (@(posedge ref_clk) // RULE14
    disable iff (reset) !strobe |=> $stable(filt_reg))
    else $error("filter moved without strobe");

  a_filt_zero_bw: assert property (@(posedge ref_clk) // RULE2
    disable iff (reset) strobe && coef == `PTR_ZERO |=> $stable(filt_reg))
    else $error("filter moved with zero bandwidth");

  // a step never passes the error nor moves away from it
  a_filt_toward_err: assert property (@(posedge ref_clk) // RULE1
    disable iff (reset) strobe && err_in >= filt_reg |=>
    filt_reg >= $past(filt_reg) && filt_reg <= $past(err_in))
    else $error("filter did not step toward the error");

endmodule : ptr_err_filter

/* core/ptr_regulator.sv */
// process pi trim regulator with apb register access
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "ptr_consts.svh"
// Overview of operation
// RULE1 - error is reference minus feedback, fed into a low-pass filter
// RULE2 - filter bandwidth set in rad/s; filter output drives the regulator
// RULE3 - on enable, integrator preset so output starts at preset value
// RULE4 - integral gain in 1/s, applied to per-unit error, 1 pu = 100 %
// RULE5 - integrator clamped between upper (0 to 8 pu) and lower limits
// RULE6 - clamped integrator value is readable for monitoring
// RULE7 - proportional path is filtered error times proportional gain
// RULE8 - clamped integrator plus proportional path form the raw result
// RULE9 - raw result bounded by output limits, upper one 0 to 8 pu
// RULE10 - output forced to zero unless enabled
// RULE11 - trim command bit 12 and running enable; state bit 31 shows it
// RULE12 - unconditional enable option bit 23 enables output regardless
// RULE13 - consumers use the output as speed, torque or analog trim
// RULE14 - all arithmetic advances once per update strobe, held otherwise

module ptr_regulator
  import ptr_pkg::*;
(
  input  wire logic        ref_clk,       // 250 mhz clock
  input  wire logic        reset,         // synchronous, active high
  input  wire logic        drive_running, // drive running status
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb write
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped
  output ptr_pu_t          regulator_trim_output, // trim to consumer
  output logic             trim_enabled_state     // command and running
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic        trim_enable_command_reg;
  logic        unconditional_trim_enable_reg;
  ptr_pu_t     process_reference_value_reg;
  ptr_pu_t     process_feedback_value_reg;
  ptr_pu_t     error_filter_bandwidth_reg;
  ptr_pu_t     integrator_preset_value_reg;
  ptr_pu_t     integral_gain_setting_reg;
  ptr_pu_t     integrator_upper_clamp_reg;
  ptr_pu_t     integrator_lower_clamp_reg;
  ptr_pu_t     proportional_gain_setting_reg;
  ptr_pu_t     output_upper_clamp_reg;
  ptr_pu_t     output_lower_clamp_reg;
  ptr_pu_t     integ_reg;
  ptr_pu_t     out_reg;
  logic        en_reg;
  logic        state_reg;
  logic        running_reg;
  logic [11:0] div_reg;
  logic        strobe;
  logic [31:0] prdata_reg;
  logic        apb_wr;
  logic        mapped;
  ptr_pu_t     wdata_upper;

  ////////////////////////////////////////////////////////////////////////
  // update strobe divider

  // one-cycle enable every update period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_reg <= 12'h000;
    end else if (div_reg == 12'(`PTR_UPDATE_CYC - 1)) begin
      div_reg <= 12'h000;
    end else begin
      div_reg <= div_reg + 12'h001;
    end
  end

  assign strobe = (div_reg == 12'(`PTR_UPDATE_CYC - 1)); // RULE14

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  // address decode of mapped offsets
  always_comb begin
    case (paddr)
      `PTR_CMD_OFS, `PTR_OPT_OFS, `PTR_STATE_OFS, `PTR_REF_OFS,
      `PTR_FBK_OFS, `PTR_BW_OFS, `PTR_PRESET_OFS, `PTR_KI_OFS,
      `PTR_IHI_OFS, `PTR_ILO_OFS, `PTR_KP_OFS, `PTR_OHI_OFS,
      `PTR_OLO_OFS, `PTR_IMON_OFS, `PTR_OUT_OFS: mapped = 1'b1;
      default:                                   mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign apb_wr  = psel && penable && pwrite && mapped;
  // upper limits stay within 0 to 8 pu
  assign wdata_upper = ptr_clamp(pwdata, `PTR_ZERO, `PTR_MAX_UPPER);

  // software-written settings
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trim_enable_command_reg       <= 1'b0;
      unconditional_trim_enable_reg <= 1'b0;
      process_reference_value_reg   <= `PTR_ZERO;
      process_feedback_value_reg    <= `PTR_ZERO;
      error_filter_bandwidth_reg    <= `PTR_ZERO;
      integrator_preset_value_reg   <= `PTR_ZERO;
      integral_gain_setting_reg     <= `PTR_ZERO;
      integrator_upper_clamp_reg    <= `PTR_RST_IHI;
      integrator_lower_clamp_reg    <= `PTR_RST_ILO;
      proportional_gain_setting_reg <= `PTR_ZERO;
      output_upper_clamp_reg        <= `PTR_RST_OHI;
      output_lower_clamp_reg        <= `PTR_RST_OLO;
    end else if (apb_wr) begin
      case (paddr)
        `PTR_CMD_OFS:
          trim_enable_command_reg <= pwdata[`PTR_TRIM_EN_BIT];
        `PTR_OPT_OFS:
          unconditional_trim_enable_reg <= pwdata[`PTR_UNCOND_EN_BIT];
        `PTR_REF_OFS:    process_reference_value_reg   <= pwdata;
        `PTR_FBK_OFS:    process_feedback_value_reg    <= pwdata;
        `PTR_BW_OFS:     error_filter_bandwidth_reg    <= pwdata;
        `PTR_PRESET_OFS: integrator_preset_value_reg   <= pwdata;
        `PTR_KI_OFS:     integral_gain_setting_reg     <= pwdata;
        `PTR_IHI_OFS:    integrator_upper_clamp_reg    <= wdata_upper; // RULE5
        `PTR_ILO_OFS:    integrator_lower_clamp_reg    <= pwdata;
        `PTR_KP_OFS:     proportional_gain_setting_reg <= pwdata;
        `PTR_OHI_OFS:    output_upper_clamp_reg        <= wdata_upper; // RULE9
        `PTR_OLO_OFS:    output_lower_clamp_reg        <= pwdata;
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PTR_CMD_OFS:    prdata_reg <= 32'({trim_enable_command_reg,
                                            12'h000});
        `PTR_OPT_OFS:    prdata_reg <= 32'({unconditional_trim_enable_reg,
                                            23'h00000});
        `PTR_STATE_OFS:  prdata_reg <= {state_reg, 29'h0000000,
                                        running_reg, 1'b0};
        `PTR_REF_OFS:    prdata_reg <= process_reference_value_reg;
        `PTR_FBK_OFS:    prdata_reg <= process_feedback_value_reg;
        `PTR_BW_OFS:     prdata_reg <= error_filter_bandwidth_reg;
        `PTR_PRESET_OFS: prdata_reg <= integrator_preset_value_reg;
        `PTR_KI_OFS:     prdata_reg <= integral_gain_setting_reg;
        `PTR_IHI_OFS:    prdata_reg <= integrator_upper_clamp_reg;
        `PTR_ILO_OFS:    prdata_reg <= integrator_lower_clamp_reg;
        `PTR_KP_OFS:     prdata_reg <= proportional_gain_setting_reg;
        `PTR_OHI_OFS:    prdata_reg <= output_upper_clamp_reg;
        `PTR_OLO_OFS:    prdata_reg <= output_lower_clamp_reg;
        `PTR_IMON_OFS:   prdata_reg <= integ_reg; // RULE6
        `PTR_OUT_OFS:    prdata_reg <= out_reg;
        default:         prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // error and filter

  ptr_pu_t err;
  ptr_pu_t filt;
  ptr_pu_t bw_coef;

  assign err = ptr_sat(64'(process_reference_value_reg) -
                       64'(process_feedback_value_reg)); // RULE1
  assign bw_coef = ptr_per_step(error_filter_bandwidth_reg,
                                32'(`PTR_DT_Q32)); // RULE2

  ptr_err_filter u_filter (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .strobe   (strobe),
    .err_in   (err),
    .coef     (bw_coef),
    .filt_out (filt)
  );

  ////////////////////////////////////////////////////////////////////////
  // pi arithmetic

  logic    en_now;
  logic    cmd_run;
  ptr_pu_t prop;
  ptr_pu_t ki_coef;
  ptr_pu_t integ_raw;
  ptr_pu_t integ_next;
  ptr_pu_t sum;
  ptr_pu_t out_next;

  // enable conditions
  assign cmd_run = trim_enable_command_reg && drive_running; // RULE11
  assign en_now  = cmd_run || unconditional_trim_enable_reg; // RULE12

  // proportional, integral and limited sum
  always_comb begin
    prop    = ptr_mul(proportional_gain_setting_reg, filt); // RULE7
    ki_coef = ptr_per_step(integral_gain_setting_reg,
                           32'(`PTR_DT_Q32)); // RULE4
    if (!en_now) begin
      integ_raw = `PTR_ZERO;
    end else if (!en_reg) begin
      integ_raw = ptr_sat(64'(integrator_preset_value_reg) -
                          64'(prop)); // RULE3
    end else begin
      integ_raw = ptr_sat(64'(integ_reg) +
                          64'(ptr_mul(ki_coef, filt))); // RULE4
    end
    integ_next = ptr_clamp(integ_raw, integrator_lower_clamp_reg,
                           integrator_upper_clamp_reg); // RULE5
    sum      = ptr_sat(64'(integ_next) + 64'(prop)); // RULE8
    out_next = en_now ? ptr_clamp(sum, output_lower_clamp_reg,
                                  output_upper_clamp_reg) // RULE9
                      : `PTR_ZERO; // RULE10
  end

  // regulator state, advanced only on the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      integ_reg <= `PTR_ZERO;
      out_reg   <= `PTR_ZERO;
      en_reg    <= 1'b0;
    end else if (strobe) begin
      integ_reg <= integ_next; // RULE14
      out_reg   <= out_next;
      en_reg    <= en_now;
    end
  end

  // enable state bit and running mirror
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg   <= 1'b0;
      running_reg <= 1'b0;
    end else begin
      state_reg   <= cmd_run; // RULE11
      running_reg <= drive_running;
    end
  end

  assign regulator_trim_output = out_reg; // RULE13
  assign trim_enabled_state    = state_reg;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  logic preset_fits;

  // preset reachable inside both limit pairs
  assign preset_fits =
    integ_raw >= integrator_lower_clamp_reg &&
    integ_raw <= integrator_upper_clamp_reg &&
    integrator_preset_value_reg >= output_lower_clamp_reg &&
    integrator_preset_value_reg <= output_upper_clamp_reg &&
    !(64'(integrator_preset_value_reg) - 64'(prop) > 64'sh7fff_ffff) &&
    !(64'(integrator_preset_value_reg) - 64'(prop) < -64'sh8000_0000);

  sequence s_enable_edge;
    strobe && en_now && !en_reg && preset_fits;
  endsequence

  a_preset_on_enable: assert property (@(posedge ref_clk) // RULE3
    disable iff (reset)
    s_enable_edge |=> out_reg == $past(integrator_preset_value_reg))
    else $error("output did not start at preset");

  a_out_zero_off: assert property (@(posedge ref_clk) // RULE10
    disable iff (reset) strobe && !en_now |=> out_reg == `PTR_ZERO && !en_reg)
    else $error("disabled output not zero");

  a_state_follows: assert property (@(posedge ref_clk) // RULE11
    disable iff (reset) trim_enable_command_reg && drive_running |=> state_reg)
    else $error("trim state bit not set");

  a_uncond_enable: assert property (@(posedge ref_clk) // RULE12
    disable iff (reset) strobe && unconditional_trim_enable_reg |=> en_reg)
    else $error("unconditional enable ignored");

  a_integ_in_limits: assert property (@(posedge ref_clk) // RULE5
    disable iff (reset)
    strobe && !apb_wr &&
    integrator_lower_clamp_reg <= integrator_upper_clamp_reg |=>
    integ_reg <= integrator_upper_clamp_reg &&
    integ_reg >= integrator_lower_clamp_reg)
    else $error("integrator outside its limits");

  a_out_in_limits: assert property (@(posedge ref_clk) // RULE9
    disable iff (reset) strobe && en_now && !apb_wr &&
    output_lower_clamp_reg <= output_upper_clamp_reg |=>
    out_reg <= output_upper_clamp_reg &&
    out_reg >= output_lower_clamp_reg)
    else $error("output outside its limits");

  a_sum_passes: assert property (@(posedge ref_clk) // RULE8
    disable iff (reset) strobe && en_now && sum > output_lower_clamp_reg &&
    sum < output_upper_clamp_reg |=> out_reg == $past(sum) &&
    $past(sum) == ptr_sat(64'($past(integ_next)) +
                          64'($past(prop))))
    else $error("output is not integrator plus proportional");

  a_zero_ki_holds: assert property (@(posedge ref_clk) // RULE4
    disable iff (reset) strobe && en_now && en_reg &&
    ki_coef == `PTR_ZERO && !apb_wr &&
    integ_reg >= integrator_lower_clamp_reg &&
    integ_reg <= integrator_upper_clamp_reg |=> integ_reg == $past(integ_reg))
    else $error("integrator moved with zero gain");

  a_hold_between: assert property (@(posedge ref_clk) // RULE14
    disable iff (reset) !strobe |=> $stable(integ_reg) && $stable(out_reg))
    else $error("regulator moved without strobe");

  a_strobe_period: assert property (@(posedge ref_clk) // RULE14
    disable iff (reset) strobe |=> !strobe [*8])
    else $error("update strobes too close");

  a_mon_readback: assert property (@(posedge ref_clk) // RULE6
    disable iff (reset) psel && !penable && !pwrite &&
    paddr == `PTR_IMON_OFS |=> prdata == $past(integ_reg))
    else $error("integrator monitor mismatch");

  a_prop_zero_kp: assert property (@(posedge ref_clk) // RULE7
    disable iff (reset) proportional_gain_setting_reg == `PTR_ZERO |->
    prop == `PTR_ZERO)
    else $error("proportional path not zero with zero gain");

endmodule : ptr_regulator

/* tb/ptr_trim_consumer.sv */
// consumer model that applies the regulator trim to a speed loop
`timescale 1ns/1ns
`include "ptr_consts.svh"

module ptr_trim_consumer
  import ptr_pkg::*;
(
  input  wire logic    ref_clk,     // system clock
  input  wire logic    reset,       // synchronous, active high
  input  wire ptr_pu_t trim_in,     // regulator trim
  output ptr_pu_t      speed_cmd,   // base speed plus trim
  output logic         spacing_err  // trim moved between updates
);
  localparam ptr_pu_t BASE_SPEED = 32'sh0000_8000;
  int      gap_cnt;
  ptr_pu_t last_trim;

  //////////////////////////////////////////////////////////////////////
  // trim added to a fixed speed reference
  always_ff @(posedge ref_clk) begin
    speed_cmd <= reset ? BASE_SPEED : BASE_SPEED + trim_in;
  end

  // trim may move at most once per regulator update
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gap_cnt     <= `PTR_UPDATE_CYC;
      last_trim   <= `PTR_ZERO;
      spacing_err <= 1'b0;
    end else begin
      last_trim <= trim_in;
      if (trim_in !== last_trim) begin
        gap_cnt <= 0;
        if (gap_cnt < `PTR_UPDATE_CYC - 1) begin
          spacing_err <= 1'b1;
        end
      end else if (gap_cnt < `PTR_UPDATE_CYC) begin
        gap_cnt <= gap_cnt + 1;
      end
    end
  end
endmodule : ptr_trim_consumer

/* tb/ptr_regulator_bench.sv */
// self-checking bench of the process trim regulator
`timescale 1ns/1ns
`include "ptr_consts.svh"

module ptr_regulator_bench
  import ptr_pkg::*;
;
  logic        ref_clk;
  logic        reset;
  logic        drive_running;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  ptr_pu_t     trim_out;
  logic        trim_state;
  logic        spacing_err;
  logic [32:0] exp_q[$];
  int          n_fail;
  int          num_checks;
  int          cyc = 0;
  int          seed;
  ptr_pu_t     preset;

  //////////////////////////////////////////////////////////////////////
  // clock, design and far-side consumer
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  ptr_regulator dut_u (
    .ref_clk(ref_clk), .reset(reset), .drive_running(drive_running),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .regulator_trim_output(trim_out),
    .trim_enabled_state(trim_state)
  );

  ptr_trim_consumer cons_u (
    .ref_clk(ref_clk), .reset(reset), .trim_in(trim_out),
    .speed_cmd(), .spacing_err(spacing_err)
  );

  //////////////////////////////////////////////////////////////////////
  // compare and report
  task check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // one apb transfer, expected answer noted first
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [32:0] e);
    exp_q.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task wait_upd(input int n);
    repeat (n * `PTR_UPDATE_CYC + 4) @(posedge ref_clk);
  endtask : wait_upd

  //////////////////////////////////////////////////////////////////////
  // watcher: each completed transfer against the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready) begin
      check(pwrite ? {pslverr, 32'h0} : {pslverr, prdata},
            exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      stop_test();
    end
  end

  // main sequence
  initial begin
    seed = 46;
    n_fail = 0;
    num_checks = 0;
    reset = 1'b1;
    drive_running = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // reset values, refusal, clamped limit writes
    rd(`PTR_IHI_OFS, `PTR_RST_IHI);
    rd(`PTR_ILO_OFS, `PTR_RST_ILO);
    rd(`PTR_OHI_OFS, `PTR_RST_OHI);
    rd(`PTR_OLO_OFS, `PTR_RST_OLO);
    rd(`PTR_OUT_OFS, `PTR_ZERO);
    xfer(1'b0, 8'h3c, 32'h0, 33'h1_0000_0000);
    wr(`PTR_IHI_OFS, 32'h0009_0000);
    rd(`PTR_IHI_OFS, `PTR_MAX_UPPER);
    wr(`PTR_OHI_OFS, 32'h0009_0000);
    rd(`PTR_OHI_OFS, `PTR_MAX_UPPER);
    // working limits, fast filter, random preset, enable
    wr(`PTR_IHI_OFS, `PTR_ONE_PU);
    wr(`PTR_OHI_OFS, 32'h0002_0000);
    wr(`PTR_OLO_OFS, 32'hfffe_0000);
    wr(`PTR_BW_OFS, 32'h7fff_0000);
    preset = $random(seed) & 32'h0000_ffff;
    wr(`PTR_PRESET_OFS, preset);
    wr(`PTR_CMD_OFS, 32'h0000_1000);
    drive_running <= 1'b1;
    wait_upd(1);
    rd(`PTR_OUT_OFS, preset);
    rd(`PTR_IMON_OFS, preset);
    rd(`PTR_STATE_OFS, 32'h8000_0002);
    wr(`PTR_OUT_OFS, 32'h0);
    rd(`PTR_OUT_OFS, preset);
    check(trim_state, 1'b1);
    check(trim_out, preset);
    // proportional path into the upper output limit
    wr(`PTR_KP_OFS, `PTR_MAX_UPPER);
    wr(`PTR_REF_OFS, `PTR_ONE_PU);
    wait_upd(10);
    rd(`PTR_OUT_OFS, 32'h0002_0000);
    rd(`PTR_IMON_OFS, preset);
    // integrator climbs into its upper clamp
    wr(`PTR_KP_OFS, 32'h0);
    wr(`PTR_KI_OFS, 32'h7fff_0000);
    wait_upd(4);
    rd(`PTR_IMON_OFS, `PTR_ONE_PU);
    rd(`PTR_OUT_OFS, `PTR_ONE_PU);
    // negative error from the feedback side
    wr(`PTR_REF_OFS, 32'h0);
    wr(`PTR_FBK_OFS, `PTR_ONE_PU);
    wr(`PTR_KP_OFS, `PTR_MAX_UPPER);
    wait_upd(12);
    rd(`PTR_IMON_OFS, `PTR_RST_ILO);
    rd(`PTR_OUT_OFS, 32'hfffe_0000);
    // drive stopped: output forced to zero
    wr(`PTR_KP_OFS, 32'h0);
    wr(`PTR_KI_OFS, 32'h0);
    wr(`PTR_BW_OFS, 32'h0);
    drive_running <= 1'b0;
    wait_upd(1);
    rd(`PTR_OUT_OFS, `PTR_ZERO);
    rd(`PTR_STATE_OFS, 32'h0);
    check(trim_state, 1'b0);
    // unconditional enable while stopped
    wr(`PTR_OPT_OFS, 32'h0080_0000);
    wait_upd(1);
    rd(`PTR_OUT_OFS, preset);
    check(trim_out, preset);
    check(spacing_err, 1'b0);
    stop_test();
  end
endmodule : ptr_regulator_bench
